// file: sim/aex_unit_props.sv
`timescale 1ns/1ps
module exit_unit_props (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        MODE64,
    input wire logic [63:0] ASYNC_EXIT_POINTER,
    input wire logic [63:0] ENCLAVE_BASE_ADDRESS,
    input wire logic [63:0] SAVE_AREA_OFFSET,
    input wire logic [31:0] SAVE_SLOT_COUNT,
    input wire logic [31:0] SAVE_FRAME_PAGES,
    input wire logic        ENCLAVE_MODE,
    input wire logic [31:0] CURRENT_SAVE_SLOT,
    input wire logic        GPR_WE,
    input wire logic [3:0]  GPR_WR_IDX,
    input wire logic [63:0] GPR_WR_DATA,
    input wire logic        MEM_WE,
    input wire logic [63:0] MEM_ADDR,
    input wire logic        XSAVE_REQ,
    input wire logic [63:0] XSAVE_ADDR,
    input wire logic        SEG_RESTORE,
    input wire logic        EXIT_DONE,
    input wire logic        ENTER_OK,
    input wire logic        RESUME_OK,
    input wire logic [63:0] RELOAD_ADDR
);
    logic [63:0] frame_base;
    logic [63:0] frame_bytes;
    assign frame_bytes = {32'h0, SAVE_FRAME_PAGES} << 12;
    assign frame_base  = ENCLAVE_BASE_ADDRESS + SAVE_AREA_OFFSET
                       + (({32'h0, CURRENT_SAVE_SLOT} * {32'h0, SAVE_FRAME_PAGES}) << 12);

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    // Push burst runs with the mode already cleared
    sequence s_push_burst;
        (!EXIT_DONE && !ENCLAVE_MODE) [*6] ##1 EXIT_DONE;
    endsequence
    sequence s_save_burst;
        MEM_WE [*8];
    endsequence

    a_enter_slot_free: assert property (ENTER_OK |-> ENCLAVE_MODE
        && $past(CURRENT_SAVE_SLOT) < SAVE_SLOT_COUNT)
        else $error("enter granted without a free save slot");
    a_exit_slot_step: assert property ($fell(ENCLAVE_MODE) |-> SEG_RESTORE
        && CURRENT_SAVE_SLOT == $past(CURRENT_SAVE_SLOT) + 32'h1)
        else $error("exit did not advance the slot or restore segments");
    a_exit_then_done: assert property ($fell(ENCLAVE_MODE) |=> s_push_burst)
        else $error("exit completion not seen after leaving enclave mode");
    a_xsave_at_frame: assert property (XSAVE_REQ |->
        XSAVE_ADDR == frame_base ##1 s_save_burst)
        else $error("extended save not at selected frame base");
    a_gpr_area_top: assert property (XSAVE_REQ |=>
        MEM_ADDR == $past(XSAVE_ADDR) + frame_bytes - 64'h90)
        else $error("first register save word at wrong address");
    a_resume_pops: assert property (RESUME_OK |-> RELOAD_ADDR == frame_base
        && CURRENT_SAVE_SLOT == $past(CURRENT_SAVE_SLOT) - 32'h1)
        else $error("resume did not release the latest frame");
    a_leaf_in_rax: assert property (GPR_WE && GPR_WR_IDX == aex_pkg::GPR_RAX
        |-> GPR_WR_DATA == aex_pkg::RESUME_LEAF_INDEX)
        else $error("accumulator not loaded with resume leaf index");
    a_ptr_in_rcx: assert property (GPR_WE && GPR_WR_IDX == aex_pkg::GPR_RCX |->
        GPR_WR_DATA == (MODE64 ? ASYNC_EXIT_POINTER : ASYNC_EXIT_POINTER & 64'hFFFF_FFFF))
        else $error("counter register not loaded with exit pointer");
    a_high_regs_zero: assert property (GPR_WE && GPR_WR_IDX >= aex_pkg::GPR_R8
        |-> MODE64 && GPR_WR_DATA == 64'h0)
        else $error("upper register write wrong for mode");
endmodule : exit_unit_props

// file: sim/gpr_file_model.sv
`timescale 1ns/1ps
// Register file behind the exit unit; the bench reads it after an exit
module gpr_file_model (
    input  wire logic        CLOCK,
    input  wire logic [3:0]  GPR_RD_IDX,
    input  wire logic        GPR_WE,
    input  wire logic [3:0]  GPR_WR_IDX,
    input  wire logic [63:0] GPR_WR_DATA,
    output logic      [63:0] GPR_RD_DATA
);
    logic [63:0] gpr_ff [16];

    // Same-cycle read data, as the save walk expects
    assign GPR_RD_DATA = gpr_ff[GPR_RD_IDX];

    always @(posedge CLOCK) begin
        if (GPR_WE) begin
            gpr_ff[GPR_WR_IDX] <= GPR_WR_DATA;
        end
    end
endmodule : gpr_file_model

// file: sim/test_async_enclave_exit_unit.sv
`timescale 1ns/1ps
module test_async_enclave_exit_unit;
    logic        CLOCK, RST = 1'b1, EVENT_VALID = 1'b0, ENTER_LEAF_REQ = 1'b0;
    logic        RESUME_LEAF_REQ = 1'b0, MODE64 = 1'b0, PRIV_CHANGE = 1'b0;
    logic        STACK_TABLE_SEL = 1'b0, HAS_ERROR_CODE = 1'b0, ENCLAVE_MODE, GPR_WE, MEM_WE;
    logic        MEM_SIZE64, XSAVE_REQ, SEG_RESTORE, EXIT_DONE, ENTER_OK, ENTER_FAIL;
    logic        RESUME_OK, RESUME_FAIL;
    logic [3:0]  GPR_RD_IDX, GPR_WR_IDX;
    logic [15:0] CS_IN, SS_IN, FS_IN = '0, GS_IN = '0, FS_OUT, GS_OUT, fs_exp, gs_exp;
    logic [31:0] SAVE_SLOT_COUNT, SAVE_FRAME_PAGES, CURRENT_SAVE_SLOT;
    logic [63:0] ERROR_CODE = '0, RIP_IN = '0, FLAGS_IN = '0, RING_STACK_PTR, STACK_TABLE_PTR;
    logic [63:0] SAVED_USER_STACK_PTR, SAVED_USER_FRAME_PTR, THREAD_CONTROL_STRUCT;
    logic [63:0] ASYNC_EXIT_POINTER, ENCLAVE_BASE_ADDRESS, SAVE_AREA_OFFSET, GPR_RD_DATA;
    logic [63:0] GPR_WR_DATA, MEM_ADDR, MEM_WDATA, XSAVE_ADDR, EXIT_STACK_PTR, RELOAD_ADDR;
    logic [63:0] wa[$], wd[$];
    int          n_fail = 0, tests_run = 0, cycles = 0, seed;

    async_enclave_exit_unit i_dut (.*);
    gpr_file_model i_rf (.*);

    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // Memory writes are logged as the design issues them
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (MEM_WE === 1'b1) begin
            wa.push_back(MEM_ADDR);
            wd.push_back(MEM_WDATA);
        end
        if (cycles == 3000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [63:0] fbase(input logic [31:0] s);
        return ENCLAVE_BASE_ADDRESS + SAVE_AREA_OFFSET
             + (({32'h0, s} * {32'h0, SAVE_FRAME_PAGES}) << 12);
    endfunction : fbase

    function automatic logic [63:0] synth(input int i);
        case (i)
            0: return 64'h3;
            1: return ASYNC_EXIT_POINTER;
            3: return THREAD_CONTROL_STRUCT;
            4: return SAVED_USER_STACK_PTR;
            5: return SAVED_USER_FRAME_PTR;
            default: return 64'h0;
        endcase
    endfunction : synth

    task automatic leaf(input logic ent, input logic ok);
        logic [31:0] s;
        s = CURRENT_SAVE_SLOT;
        FS_IN = 16'($random(seed));
        GS_IN = 16'($random(seed));
        ENTER_LEAF_REQ = ent;
        RESUME_LEAF_REQ = !ent;
        @(negedge CLOCK);
        ENTER_LEAF_REQ = 1'b0;
        RESUME_LEAF_REQ = 1'b0;
        check(64'(ent ? ENTER_OK : RESUME_OK), 64'(ok));
        check(64'(ent ? ENTER_FAIL : RESUME_FAIL), 64'(!ok));
        check(64'(ENCLAVE_MODE), 64'(ok));
        check(64'(CURRENT_SAVE_SLOT), 64'((ok && !ent) ? s - 32'h1 : s));
        if (ok && !ent) check(RELOAD_ADDR, fbase(s - 32'h1));
        if (ok) {fs_exp, gs_exp} = {FS_IN, GS_IN};
    endtask : leaf

    task automatic do_exit(input logic m64, input logic pc, input logic interrupt_stack_table, input logic ec);
        logic [63:0] pre[16], it[6], msk, sp, fe;
        logic        en[6];
        logic [31:0] s;
        int          k, n, nw;
        s = CURRENT_SAVE_SLOT;
        msk = m64 ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
        fe = fbase(s) + ({32'h0, SAVE_FRAME_PAGES} << 12);
        MODE64 = m64;
        PRIV_CHANGE = pc;
        STACK_TABLE_SEL = interrupt_stack_table;
        HAS_ERROR_CODE = ec;
        RIP_IN = {$random(seed), $random(seed)};
        FLAGS_IN = {$random(seed), $random(seed)};
        ERROR_CODE = {$random(seed), $random(seed)};
        foreach (pre[i]) pre[i] = i_rf.gpr_ff[i];
        wa.delete();
        wd.delete();
        EVENT_VALID = 1'b1;
        @(negedge CLOCK);
        EVENT_VALID = 1'b0;
        for (n = 0; n < 80 && EXIT_DONE !== 1'b1; n++) @(negedge CLOCK);
        check(64'(n < 80), 64'h1);
        sp = pc ? RING_STACK_PTR : SAVED_USER_STACK_PTR;
        if (m64 && interrupt_stack_table) sp = STACK_TABLE_PTR;
        if (m64) sp = sp & 64'hFFFF_FFFF_FFFF_FFF0;
        it = '{64'(SS_IN), SAVED_USER_STACK_PTR, FLAGS_IN & ~64'h1_08D5, 64'(CS_IN),
               ASYNC_EXIT_POINTER, ERROR_CODE};
        en = '{m64 | pc, m64 | pc, 1'b1, 1'b1, 1'b1, ec};
        nw = 21 + 2 * int'(m64 | pc) + int'(ec);
        check(64'(wa.size()), 64'(nw));
        if (wa.size() == nw) begin
            for (k = 0; k < 18; k++) begin
                check(wa[k], fe - 64'h90 + 64'(8 * k));
                check(wd[k], k < 16 ? pre[k] : (k == 16 ? RIP_IN : FLAGS_IN));
            end
            foreach (it[j]) if (en[j]) begin
                sp = sp - (m64 ? 64'h8 : 64'h4);
                check(wa[k], sp);
                check(wd[k] & msk, it[j] & msk);
                k++;
            end
        end
        check(EXIT_STACK_PTR, sp);
        check(64'(CURRENT_SAVE_SLOT), 64'(s + 32'h1));
        check(64'(ENCLAVE_MODE), 64'h0);
        check(64'(FS_OUT), 64'(fs_exp));
        check(64'(GS_OUT), 64'(gs_exp));
        check(64'(MEM_SIZE64), 64'(m64));
        foreach (pre[i]) check(i_rf.gpr_ff[i], (i >= 8 && !m64) ? pre[i] : synth(i) & msk);
        @(negedge CLOCK);
    endtask : do_exit

    initial begin
        seed = 25312;
        foreach (i_rf.gpr_ff[i]) i_rf.gpr_ff[i] = {$random(seed), $random(seed)};
        {CS_IN, SS_IN} = $random(seed);
        RING_STACK_PTR = {$random(seed), $random(seed)};
        STACK_TABLE_PTR = {$random(seed), $random(seed)};
        SAVED_USER_STACK_PTR = {$random(seed), $random(seed)};
        SAVED_USER_FRAME_PTR = {$random(seed), $random(seed)};
        THREAD_CONTROL_STRUCT = {$random(seed), $random(seed)};
        ASYNC_EXIT_POINTER = {$random(seed), $random(seed)};
        ENCLAVE_BASE_ADDRESS = {$random(seed), $random(seed)};
        SAVE_AREA_OFFSET = {$random(seed), $random(seed)};
        SAVE_SLOT_COUNT = 32'h3;
        SAVE_FRAME_PAGES = 32'(1 + ($random(seed) & 3));
        repeat (12) @(negedge CLOCK);
        RST = 1'b0;
        leaf(1'b0, 1'b0);
        leaf(1'b1, 1'b1);
        do_exit(1'b1, 1'b1, 1'b0, 1'b1);
        leaf(1'b1, 1'b1);
        do_exit(1'b0, 1'b0, 1'b0, 1'b0);
        leaf(1'b1, 1'b1);
        do_exit(1'b0, 1'b1, 1'b0, 1'b1);
        leaf(1'b1, 1'b0);
        leaf(1'b0, 1'b1);
        do_exit(1'b1, 1'b0, 1'b1, 1'b0);
        wa.delete();
        EVENT_VALID = 1'b1;
        repeat (4) @(negedge CLOCK);
        EVENT_VALID = 1'b0;
        check(64'(wa.size()), 64'h0);
        conclude();
    end
endmodule : test_async_enclave_exit_unit

bind async_enclave_exit_unit exit_unit_props i_props (.*);

// file: src/aex_pkg.sv
package aex_pkg;

    localparam logic [63:0] RESUME_LEAF_INDEX = 64'h0000_0000_0000_0003;
    localparam int          PAGE_SHIFT        = 12;
    localparam logic [63:0] GPR_AREA_BYTES    = 64'h0000_0000_0000_0090;
    localparam logic [4:0]  SAVE_LAST_IDX     = 5'h11;
    localparam logic [4:0]  RIP_SAVE_IDX      = 5'h10;
    localparam logic [4:0]  GPR_LAST_IDX      = 5'h0F;
    localparam logic [2:0]  PUSH_LAST_IDX     = 3'h5;
    localparam logic [63:0] FLAGS_CLEAR_MASK  = 64'h0000_0000_0001_08D5;
    localparam logic [63:0] STACK_ALIGN_MASK  = 64'hFFFF_FFFF_FFFF_FFF0;
    localparam logic [63:0] LOW32_MASK        = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] STEP64            = 64'h0000_0000_0000_0008;
    localparam logic [63:0] STEP32            = 64'h0000_0000_0000_0004;
    localparam logic [31:0] SLOT_RESET        = 32'h0000_0000;

    localparam logic [3:0]  GPR_RAX = 4'h0;
    localparam logic [3:0]  GPR_RCX = 4'h1;
    localparam logic [3:0]  GPR_RBX = 4'h3;
    localparam logic [3:0]  GPR_RSP = 4'h4;
    localparam logic [3:0]  GPR_RBP = 4'h5;
    localparam logic [3:0]  GPR_R8  = 4'h8;

    localparam logic [2:0]  PUSH_SS    = 3'h0;
    localparam logic [2:0]  PUSH_RSP   = 3'h1;
    localparam logic [2:0]  PUSH_FLAGS = 3'h2;
    localparam logic [2:0]  PUSH_CS    = 3'h3;
    localparam logic [2:0]  PUSH_RIP   = 3'h4;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_SAVE  = 5'h02,
        ST_SYNTH = 5'h04,
        ST_PUSH  = 5'h08,
        ST_DONE  = 5'h10
    } state_t;

endpackage : aex_pkg

// file: src/async_enclave_exit_unit.sv
`timescale 1ns/1ps
// Functional notes
// RULE1 - Exit events leave enclave, clearing mode first (code clears it after the save writes, in the cycle of the R15 synthetic step, before the pushes)
// RULE2 - Save registers, then overwrite with synthetic values
// RULE3 - Push async exit pointer as return address
// RULE4 - Restore stack and frame pointers from frame
// RULE5 - Stack: new ring, current, or table
// RULE6 - Exit stack matches ordinary event delivery
// RULE7 - RAX=3, RBX=thread struct, RCX=exit pointer
// RULE8 - Zero RDX/RSI/RDI; R8-R15 zero only 64-bit
// RULE9 - Synthetic values 32-bit or 64-bit by mode
// RULE10 - Clear CF PF AF ZF SF OF RF
// RULE11 - Select frame by slot, save, load, increment
// RULE12 - Frame size is page count times 4K
// RULE13 - Frame stack at base plus save offset
// RULE14 - Software sizes frame for all saved state
// RULE15 - Extended state region uses standard save format
// RULE16 - Enter needs current slot below slot count
// RULE17 - Enter after exit reserves next frame
// RULE18 - Resume reloads latest frame and frees it
// RULE19 - Last slot consumed blocks further entry
// RULE20 - Restore FS and GS from last entry
// RULE21 - Frame address: base+offset+slot*pages*4096
module async_enclave_exit_unit (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        EVENT_VALID,
    input  wire logic        MODE64,
    input  wire logic        PRIV_CHANGE,
    input  wire logic        STACK_TABLE_SEL,
    input  wire logic        HAS_ERROR_CODE,
    input  wire logic [63:0] ERROR_CODE,
    input  wire logic [63:0] RING_STACK_PTR,
    input  wire logic [63:0] STACK_TABLE_PTR,
    input  wire logic [15:0] CS_IN,
    input  wire logic [15:0] SS_IN,
    input  wire logic [63:0] RIP_IN,
    input  wire logic [63:0] FLAGS_IN,
    input  wire logic [63:0] GPR_RD_DATA,
    input  wire logic [63:0] SAVED_USER_STACK_PTR,
    input  wire logic [63:0] SAVED_USER_FRAME_PTR,
    input  wire logic [63:0] THREAD_CONTROL_STRUCT,
    input  wire logic [63:0] ASYNC_EXIT_POINTER,
    input  wire logic [63:0] ENCLAVE_BASE_ADDRESS,
    input  wire logic [63:0] SAVE_AREA_OFFSET,
    input  wire logic [31:0] SAVE_SLOT_COUNT,
    input  wire logic [31:0] SAVE_FRAME_PAGES,
    input  wire logic        ENTER_LEAF_REQ,
    input  wire logic        RESUME_LEAF_REQ,
    input  wire logic [15:0] FS_IN,
    input  wire logic [15:0] GS_IN,
    output logic             ENCLAVE_MODE,
    output logic [31:0]      CURRENT_SAVE_SLOT,
    output logic [3:0]       GPR_RD_IDX,
    output logic             GPR_WE,
    output logic [3:0]       GPR_WR_IDX,
    output logic [63:0]      GPR_WR_DATA,
    output logic             MEM_WE,
    output logic             MEM_SIZE64,
    output logic [63:0]      MEM_ADDR,
    output logic [63:0]      MEM_WDATA,
    output logic             XSAVE_REQ,
    output logic [63:0]      XSAVE_ADDR,
    output logic             SEG_RESTORE,
    output logic [15:0]      FS_OUT,
    output logic [15:0]      GS_OUT,
    output logic             EXIT_DONE,
    output logic [63:0]      EXIT_STACK_PTR,
    output logic             ENTER_OK,
    output logic             ENTER_FAIL,
    output logic             RESUME_OK,
    output logic             RESUME_FAIL,
    output logic [63:0]      RELOAD_ADDR
);

    typedef struct packed {
        aex_pkg::state_t state;
        logic [4:0]      idx;
        logic [31:0]     slot;
        logic            in_enclave;
        logic            mode64;
        logic            switch_stack;
        logic [63:0]     sp;
        logic [63:0]     frame;
        logic [63:0]     frame_end;
        logic [63:0]     flags;
        logic [15:0]     fs;
        logic [15:0]     gs;
        logic [3:0]      rd_idx;
        logic            gpr_we;
        logic [3:0]      wr_idx;
        logic [63:0]     wr_data;
        logic            mem_we;
        logic            mem_size64;
        logic [63:0]     mem_addr;
        logic [63:0]     mem_wdata;
        logic            xsave_req;
        logic            seg_restore;
        logic            done;
        logic            enter_ok;
        logic            enter_fail;
        logic            resume_ok;
        logic            resume_fail;
        logic [63:0]     reload_addr;
    } regs_t;

    regs_t       r_ff;
    regs_t       nxt_r;
    logic [63:0] cur_base;
    logic [63:0] cur_end;
    logic [63:0] prev_base;
    logic [31:0] prev_slot;

    assign prev_slot = r_ff.slot - 32'h0000_0001;

    save_frame_addr u_cur_frame (   // RULE13 RULE21
        .base_addr   (ENCLAVE_BASE_ADDRESS),
        .area_offset (SAVE_AREA_OFFSET),
        .slot_idx    (r_ff.slot),
        .frame_pages (SAVE_FRAME_PAGES),
        .frame_base  (cur_base),
        .frame_end   (cur_end)
    );

    save_frame_addr u_prev_frame (  // RULE18
        .base_addr   (ENCLAVE_BASE_ADDRESS),
        .area_offset (SAVE_AREA_OFFSET),
        .slot_idx    (prev_slot),
        .frame_pages (SAVE_FRAME_PAGES),
        .frame_base  (prev_base),
        .frame_end   ()
    );

    function automatic logic [63:0] fit(input logic m64, input logic [63:0] v);
        fit = m64 ? v : (v & aex_pkg::LOW32_MASK);   // RULE9
    endfunction : fit

    always_comb begin
        logic [63:0] step;
        logic [63:0] nsp;
        logic [63:0] item;
        logic        push_en;
        nxt_r             = r_ff;
        step              = r_ff.mode64 ? aex_pkg::STEP64 : aex_pkg::STEP32;
        nsp               = r_ff.sp - step;
        item              = 64'h0000_0000_0000_0000;
        push_en           = 1'b0;
        nxt_r.gpr_we      = 1'b0;
        nxt_r.mem_we      = 1'b0;
        nxt_r.xsave_req   = 1'b0;
        nxt_r.seg_restore = 1'b0;
        nxt_r.done        = 1'b0;
        nxt_r.enter_ok    = 1'b0;
        nxt_r.enter_fail  = 1'b0;
        nxt_r.resume_ok   = 1'b0;
        nxt_r.resume_fail = 1'b0;
        unique case (r_ff.state)
            aex_pkg::ST_IDLE: begin
                if (EVENT_VALID && r_ff.in_enclave) begin   // RULE1
                    nxt_r.state        = aex_pkg::ST_SAVE;
                    nxt_r.idx          = 5'h00;
                    nxt_r.rd_idx       = 4'h0;
                    nxt_r.mode64       = MODE64;
                    nxt_r.switch_stack = MODE64 | PRIV_CHANGE;
                    nxt_r.frame        = cur_base;    // RULE11 RULE12
                    nxt_r.frame_end    = cur_end;
                    nxt_r.flags        = FLAGS_IN & ~aex_pkg::FLAGS_CLEAR_MASK;   // RULE10
                    // Extended region opens the frame so the save engine sees its own layout
                    nxt_r.xsave_req    = 1'b1;        // RULE15
                    if (MODE64 && STACK_TABLE_SEL) begin       // RULE5
                        nxt_r.sp = STACK_TABLE_PTR & aex_pkg::STACK_ALIGN_MASK;
                    end else if (PRIV_CHANGE) begin
                        nxt_r.sp = MODE64 ? (RING_STACK_PTR & aex_pkg::STACK_ALIGN_MASK)
                                          : RING_STACK_PTR;
                    end else begin
                        nxt_r.sp = MODE64 ? (SAVED_USER_STACK_PTR & aex_pkg::STACK_ALIGN_MASK)
                                          : SAVED_USER_STACK_PTR;
                    end
                end else if (ENTER_LEAF_REQ) begin
                    // Slot is not advanced here: it already names the next free frame
                    if (!r_ff.in_enclave && (r_ff.slot < SAVE_SLOT_COUNT)) begin   // RULE16 RULE17
                        nxt_r.in_enclave = 1'b1;
                        nxt_r.fs         = FS_IN;
                        nxt_r.gs         = GS_IN;
                        nxt_r.enter_ok   = 1'b1;
                    end else begin
                        nxt_r.enter_fail = 1'b1;      // RULE19
                    end
                end else if (RESUME_LEAF_REQ) begin
                    if (!r_ff.in_enclave && (r_ff.slot != aex_pkg::SLOT_RESET)) begin
                        nxt_r.in_enclave  = 1'b1;
                        nxt_r.fs          = FS_IN;
                        nxt_r.gs          = GS_IN;
                        nxt_r.reload_addr = prev_base;   // RULE18
                        nxt_r.slot        = prev_slot;
                        nxt_r.resume_ok   = 1'b1;
                    end else begin
                        nxt_r.resume_fail = 1'b1;
                    end
                end
            end
            aex_pkg::ST_SAVE: begin
                // GPR area sits at the top of the frame, below it the extended state
                nxt_r.mem_we     = 1'b1;              // RULE2 RULE11
                nxt_r.mem_size64 = 1'b1;
                nxt_r.mem_addr   = r_ff.frame_end - aex_pkg::GPR_AREA_BYTES
                                   + {56'h0, r_ff.idx, 3'h0};
                if (r_ff.idx <= aex_pkg::GPR_LAST_IDX) begin
                    nxt_r.mem_wdata = GPR_RD_DATA;
                end else if (r_ff.idx == aex_pkg::RIP_SAVE_IDX) begin
                    nxt_r.mem_wdata = RIP_IN;
                end else begin
                    nxt_r.mem_wdata = FLAGS_IN;
                end
                nxt_r.rd_idx = r_ff.rd_idx + 4'h1;
                if (r_ff.idx == aex_pkg::SAVE_LAST_IDX) begin
                    nxt_r.state = aex_pkg::ST_SYNTH;
                    nxt_r.idx   = 5'h00;
                end else begin
                    nxt_r.idx = r_ff.idx + 5'h01;
                end
            end
            aex_pkg::ST_SYNTH: begin
                nxt_r.wr_idx = r_ff.idx[3:0];
                nxt_r.gpr_we = r_ff.mode64 || (r_ff.idx[3:0] < aex_pkg::GPR_R8);   // RULE8
                unique case (r_ff.idx[3:0])
                    aex_pkg::GPR_RAX: nxt_r.wr_data = aex_pkg::RESUME_LEAF_INDEX;   // RULE7
                    aex_pkg::GPR_RBX: nxt_r.wr_data = fit(r_ff.mode64, THREAD_CONTROL_STRUCT);
                    aex_pkg::GPR_RCX: nxt_r.wr_data = fit(r_ff.mode64, ASYNC_EXIT_POINTER);
                    aex_pkg::GPR_RSP: nxt_r.wr_data = fit(r_ff.mode64, SAVED_USER_STACK_PTR);   // RULE4
                    aex_pkg::GPR_RBP: nxt_r.wr_data = fit(r_ff.mode64, SAVED_USER_FRAME_PTR);
                    default:          nxt_r.wr_data = 64'h0000_0000_0000_0000;   // RULE8
                endcase
                if (r_ff.idx == aex_pkg::GPR_LAST_IDX) begin
                    nxt_r.state      = aex_pkg::ST_PUSH;
                    nxt_r.idx        = 5'h00;
                    nxt_r.in_enclave = 1'b0;          // RULE1
                    nxt_r.slot       = r_ff.slot + 32'h0000_0001;   // RULE11
                    nxt_r.seg_restore = 1'b1;         // RULE20
                end else begin
                    nxt_r.idx = r_ff.idx + 5'h01;
                end
            end
            aex_pkg::ST_PUSH: begin
                // Same frame shape as outside delivery: SS, RSP, flags, CS, RIP, error code
                unique case (r_ff.idx[2:0])            // RULE6
                    aex_pkg::PUSH_SS: begin
                        push_en = r_ff.switch_stack;
                        item    = {48'h0, SS_IN};
                    end
                    aex_pkg::PUSH_RSP: begin
                        push_en = r_ff.switch_stack;
                        item    = SAVED_USER_STACK_PTR;
                    end
                    aex_pkg::PUSH_FLAGS: begin
                        push_en = 1'b1;
                        item    = r_ff.flags;         // RULE10
                    end
                    aex_pkg::PUSH_CS: begin
                        push_en = 1'b1;
                        item    = {48'h0, CS_IN};
                    end
                    aex_pkg::PUSH_RIP: begin
                        push_en = 1'b1;
                        item    = ASYNC_EXIT_POINTER; // RULE3
                    end
                    default: begin
                        push_en = HAS_ERROR_CODE;
                        item    = ERROR_CODE;
                    end
                endcase
                if (push_en) begin
                    nxt_r.sp         = nsp;
                    nxt_r.mem_we     = 1'b1;
                    nxt_r.mem_size64 = r_ff.mode64;
                    nxt_r.mem_addr   = nsp;
                    nxt_r.mem_wdata  = fit(r_ff.mode64, item);   // RULE9
                end
                if (r_ff.idx[2:0] == aex_pkg::PUSH_LAST_IDX) begin
                    nxt_r.state = aex_pkg::ST_DONE;
                end else begin
                    nxt_r.idx = r_ff.idx + 5'h01;
                end
            end
            aex_pkg::ST_DONE: begin
                nxt_r.done  = 1'b1;
                nxt_r.state = aex_pkg::ST_IDLE;
            end
            default: begin
                nxt_r.state = aex_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            r_ff       <= '0;
            r_ff.state <= aex_pkg::ST_IDLE;
            r_ff.slot  <= aex_pkg::SLOT_RESET;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign ENCLAVE_MODE      = r_ff.in_enclave;
    assign CURRENT_SAVE_SLOT = r_ff.slot;
    assign GPR_RD_IDX        = r_ff.rd_idx;
    assign GPR_WE            = r_ff.gpr_we;
    assign GPR_WR_IDX        = r_ff.wr_idx;
    assign GPR_WR_DATA       = r_ff.wr_data;
    assign MEM_WE            = r_ff.mem_we;
    assign MEM_SIZE64        = r_ff.mem_size64;
    assign MEM_ADDR          = r_ff.mem_addr;
    assign MEM_WDATA         = r_ff.mem_wdata;
    assign XSAVE_REQ         = r_ff.xsave_req;
    assign XSAVE_ADDR        = r_ff.frame;
    assign SEG_RESTORE       = r_ff.seg_restore;
    assign FS_OUT            = r_ff.fs;
    assign GS_OUT            = r_ff.gs;
    assign EXIT_DONE         = r_ff.done;
    assign EXIT_STACK_PTR    = r_ff.sp;
    assign ENTER_OK          = r_ff.enter_ok;
    assign ENTER_FAIL        = r_ff.enter_fail;
    assign RESUME_OK         = r_ff.resume_ok;
    assign RESUME_FAIL       = r_ff.resume_fail;
    assign RELOAD_ADDR       = r_ff.reload_addr;

endmodule : async_enclave_exit_unit

// file: src/save_frame_addr.sv
`timescale 1ns/1ps
module save_frame_addr (
    input  wire logic [63:0] base_addr,
    input  wire logic [63:0] area_offset,
    input  wire logic [31:0] slot_idx,
    input  wire logic [31:0] frame_pages,
    output logic      [63:0] frame_base,
    output logic      [63:0] frame_end
);
    logic [63:0] slot_pages;
    logic [63:0] frame_bytes;

    always_comb begin
        slot_pages  = {32'h0000_0000, slot_idx} * {32'h0000_0000, frame_pages};
        frame_bytes = {32'h0000_0000, frame_pages} << aex_pkg::PAGE_SHIFT;
        frame_base  = base_addr + area_offset + (slot_pages << aex_pkg::PAGE_SHIFT);
        frame_end   = frame_base + frame_bytes;
    end
endmodule : save_frame_addr
